// >>> design/aci_pkg.sv
package aci_pkg;
   localparam logic [7:0] CH_LF      = 8'h0a;
   localparam logic [7:0] CH_CR      = 8'h0d;
   localparam logic [7:0] CMD_SET    = 8'h53; // S
   localparam logic [7:0] CMD_GET    = 8'h47; // G
   localparam logic [7:0] CMD_LOAD   = 8'h6c; // l
   localparam logic [7:0] CMD_RUN    = 8'h72; // r
   localparam logic [7:0] CMD_EXEC   = 8'h65; // e
   localparam logic [7:0] CMD_STORE  = 8'h46; // F
   localparam logic [7:0] CMD_RECALL = 8'h4c; // L
   localparam logic [7:0] CMD_HIB    = 8'h73; // s
   localparam logic [7:0] CH_ERR     = 8'h21; // '!'
   localparam logic [7:0] ERR_SYNTAX = 8'h31; // error digit for syntax
   localparam logic [7:0] ERR_ARG    = 8'h32; // bad argument
   localparam logic [7:0] ERR_PERM   = 8'h33; // permission refused
   localparam logic [7:0] ERR_BUSY   = 8'h34; // not idle
   localparam logic [7:0] ERR_VER    = 8'h35; // version mismatch
   localparam logic [7:0] ERR_EMPTY  = 8'h36; // no script
   localparam int         REG_ID_W   = 2;
   localparam int         NREG       = 4;
   localparam logic [7:0] PERM_REG   = 8'h02;
   localparam logic [7:0] PERM_MIN   = 8'h01;
   localparam logic [3:0] ERR_LEN    = 4'h2;
   localparam int         SCR_DEPTH  = 64;
   localparam logic [7:0] SCR_VER    = 8'h04;
   localparam int         HIB_GUARD_NS = 2000;
   localparam int         CLK_NS       = 100;
   localparam int         HIB_GUARD_CYC = (HIB_GUARD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] SCR_IDLE_CH = 8'h00;
endpackage

// >>> design/aci_hex.sv
`timescale 1ns/1ps
`default_nettype none
module aci_hex
   import aci_pkg::*;
(
   input  wire logic [7:0] ch,      // ascii character
   output logic            is_hex,  // character is 0-9 A-F a-f
   output logic [3:0]      nib,     // decoded value
   output logic [7:0]      asc      // ascii of nib_in
   ,input wire logic [3:0] nib_in   // nibble to encode
);
   always_comb begin
      is_hex = 1'b1;
      nib    = 4'h0;
      if (ch >= 8'h30 && ch <= 8'h39) begin
         nib = 4'(ch - 8'h30);
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
         nib = 4'(ch - 8'h37);
      end else if (ch >= 8'h61 && ch <= 8'h66) begin
         nib = 4'(ch - 8'h57);
      end else begin
         is_hex = 1'b0;
      end
      asc = (nib_in < 4'ha) ? (8'h30 + {4'h0, nib_in}) : (8'h37 + {4'h0, nib_in});
   end
endmodule
`default_nettype wire

// >>> design/aci_tx.sv
`timescale 1ns/1ps
`default_nettype none
module aci_tx
   import aci_pkg::*;
(
   input  wire logic       clk,      // system clock
   input  wire logic       rst_b,    // sync reset, active low
   input  wire logic       push,     // load one byte
   input  wire logic [7:0] din,      // byte to send
   output logic            busy,     // holding an unsent byte
   output logic            tx_valid, // byte available
   output logic [7:0]      tx_data,  // byte out
   input  wire logic       tx_ready  // host side accepts
);
   typedef struct packed {
      logic       v;
      logic [7:0] d;
   } aci_txs_type;
   aci_txs_type s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (tx_ready) begin
         s_d.v = 1'b0;
      end
      if (push) begin
         s_d.v = 1'b1;
         s_d.d = din;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign busy     = s_q.v;
   assign tx_valid = s_q.v;
   assign tx_data  = s_q.d;
endmodule
`default_nettype wire

// >>> design/aci_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - set is S, two hex id digits, value digits per register width; answer S.
// - odd-numbered registers refuse access when permission level too low.
// - get is G plus two hex id digits; answer G plus register hex value.
// - load is l line, script lines, empty line; script kept in RAM; echo l.
// - each script line parsed on arrival; syntax errors reported after the closing empty line.
// - any parse error during load wipes the whole script memory.
// - run sends r and newline first, then passes script output through.
// - script end, good or failed, is followed by one empty line, or by a !4 line if bytes arrived during the run.
// - execute is load then run; answer starts with e.
// - store copies RAM script to non-volatile memory and answers F.
// - recall copies stored script into RAM, answers L, script then runnable.
// - recall refused when stored version differs from supported version.
// - s is echoed and enters hibernate.
// - hibernate ends on any received byte or on the wake pin.
// - lines end in LF; no CR sent; received CR dropped.
// - first command byte echoed, then data, error code before the newline.
// - command letters are decoded case sensitively.
// - these commands only accepted while idle; error while script runs.
module aci_top
   import aci_pkg::*;
(
   input  wire logic       CLK_SYS,       // 10 MHz clock
   input  wire logic       RST_B,         // sync reset, active low
   input  wire logic       RX_VALID,      // received byte strobe
   input  wire logic [7:0] RX_DATA,       // received byte
   output logic            TX_VALID,      // byte to host valid
   output logic [7:0]      TX_DATA,       // byte to host
   input  wire logic       TX_READY,      // host takes byte
   input  wire logic       WAKE,          // async wake pin, active high
   output logic            RUN_START,     // pulse: start script engine
   input  wire logic       RUN_OUT_VALID, // script output byte strobe
   input  wire logic [7:0] RUN_OUT_DATA,  // script output byte
   output logic            RUN_OUT_READY, // output byte taken
   input  wire logic       RUN_DONE,      // pulse: script finished
   input  wire logic       LINE_BAD,      // syntax verdict of line in SCR_DATA
   output logic [7:0]      SCR_DATA,      // script byte written to RAM
   output logic            SCR_WE,        // script byte write strobe
   output logic            SCR_CLEAR,     // pulse: wipe script RAM
   output logic            NVM_STORE,     // pulse: copy RAM to nvm
   output logic            NVM_RECALL,    // pulse: copy nvm to RAM
   input  wire logic [7:0] NVM_VER,       // version of stored script
   output logic            HIBERNATE      // level: in hibernate
);
   // ==========================================================
   // state
   // ==========================================================
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, ST_ARGS = 9'h002, ST_LOAD = 9'h004,
      ST_RUN  = 9'h008, ST_RESP = 9'h010, ST_HIB  = 9'h020,
      ST_WAIT = 9'h040, ST_SKIP = 9'h080, ST_GUARD = 9'h100
   } aci_st_type;

   typedef struct packed {
      aci_st_type  st;
      logic [7:0]  cmd;
      logic [3:0]  nargs;
      logic [7:0]  rid;
      logic [31:0] val;
      logic [3:0]  nval;
      logic        bad;
      logic [7:0]  ecode;
      logic        ln_empty;
      logic        scr_ok;
      logic [4:0]  ridx;
      logic [3:0]  rlen;
      logic [7:0]  perm;
      logic [NREG-1:0][31:0] regs;
      logic        done;
      logic [7:0]  guard;
      logic        hold_err;
      logic        start;
      logic        we;
      logic        clr;
      logic        sto;
      logic        rec;
      logic [7:0]  sd;
      logic        run_ex;
   } aci_s_type;

   aci_s_type s_q, s_d;
   logic       tx_push, tx_busy;
   logic [7:0] tx_din;
   logic       hx_ok;
   logic [3:0] hx_nib, enc_nib;
   logic [7:0] hx_asc;
   logic       wake_s;
   logic [1:0] wake_q;

   // two-stage sync of the async wake pin
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         wake_q <= 2'b00;
      end else begin
         wake_q <= {wake_q[0], WAKE};
      end
   end
   assign wake_s = wake_q[1];

   aci_hex u_hex (
      .ch     (RX_DATA),
      .is_hex (hx_ok),
      .nib    (hx_nib),
      .asc    (hx_asc),
      .nib_in (enc_nib)
   );

   aci_tx u_tx (
      .clk      (CLK_SYS),
      .rst_b    (RST_B),
      .push     (tx_push),
      .din      (tx_din),
      .busy     (tx_busy),
      .tx_valid (TX_VALID),
      .tx_data  (TX_DATA),
      .tx_ready (TX_READY)
   );

   function automatic logic [3:0] reg_digits(input logic [7:0] id);
      case (id)
         8'h00:   reg_digits = 4'h8;
         8'h01:   reg_digits = 4'h4;
         PERM_REG: reg_digits = 4'h2;
         8'h03:   reg_digits = 4'h8;
         default: reg_digits = 4'h0;
      endcase
   endfunction

   logic rx_take;
   logic [3:0] dig;
   assign rx_take = RX_VALID && (RX_DATA != CH_CR);
   assign dig     = reg_digits(s_q.rid);
   assign enc_nib = s_q.val[31:28];

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      s_d       = s_q;
      s_d.start = 1'b0;
      s_d.we    = 1'b0;
      s_d.clr   = 1'b0;
      s_d.sto   = 1'b0;
      s_d.rec   = 1'b0;
      tx_push   = 1'b0;
      tx_din    = 8'h00;
      RUN_OUT_READY = 1'b0;
      case (s_q.st)
         ST_IDLE: begin
            if (rx_take && !tx_busy) begin
               s_d.cmd   = RX_DATA;
               s_d.bad   = 1'b0;
               s_d.ecode = 8'h00;
               s_d.nargs = 4'h0;
               s_d.nval  = 4'h0;
               s_d.val   = '0;
               s_d.rid   = 8'h00;
               tx_push   = (RX_DATA != CH_LF);
               tx_din    = RX_DATA;
               case (RX_DATA)
                  CMD_LOAD, CMD_EXEC: begin
                     s_d.clr = 1'b1;
                     s_d.scr_ok = 1'b0;
                     s_d.st = ST_SKIP;
                     s_d.run_ex = (RX_DATA == CMD_EXEC);
                  end
                  CMD_HIB: begin
                     s_d.st = ST_SKIP;
                  end
                  CH_LF: s_d.st = ST_IDLE;
                  default: s_d.st = ST_ARGS;
               endcase
            end
         end
         ST_SKIP: begin
            // drops the rest of the command line
            if (rx_take && RX_DATA == CH_LF) begin
               if (s_q.cmd == CMD_HIB) begin
                  s_d.st = ST_WAIT;
               end else begin
                  s_d.st = ST_LOAD;
                  s_d.ln_empty = 1'b1;
               end
            end
         end
         ST_ARGS: begin
            if (rx_take && RX_DATA == CH_LF) begin
               s_d.st = ST_RESP;
               s_d.rlen = 4'h0;
               if (s_q.cmd == CMD_SET || s_q.cmd == CMD_GET) begin
                  if (s_q.bad || s_q.nargs < 4'(REG_ID_W) || dig == 4'h0) begin
                     s_d.ecode = ERR_ARG;
                  end else if (s_q.rid != PERM_REG && s_q.rid[0] && s_q.perm < PERM_MIN) begin
                     s_d.ecode = ERR_PERM;
                  end else if (s_q.cmd == CMD_SET) begin
                     if (s_q.nval != dig) begin
                        s_d.ecode = ERR_ARG;
                     end else if (s_q.rid == PERM_REG) begin
                        s_d.perm = s_q.val[7:0];
                     end else begin
                        s_d.regs[s_q.rid[1:0]] = s_q.val;
                     end
                  end else if (s_q.nval != 4'h0) begin
                     s_d.ecode = ERR_ARG;
                  end else begin
                     // value left-aligned for nibble-wise send
                     s_d.val = (s_q.rid == PERM_REG) ? {s_q.perm, 24'h0} :
                               (s_q.regs[s_q.rid[1:0]] << (6'd32 - {dig, 2'b00}));
                     s_d.rlen = dig;
                  end
               end else if (s_q.cmd == CMD_STORE) begin
                  s_d.sto = s_q.scr_ok;
                  s_d.ecode = s_q.scr_ok ? 8'h00 : ERR_EMPTY;
               end else if (s_q.cmd == CMD_RECALL) begin
                  if (NVM_VER != SCR_VER) begin
                     s_d.ecode = ERR_VER;
                  end else begin
                     s_d.rec = 1'b1;
                     s_d.scr_ok = 1'b1;
                  end
               end else if (s_q.cmd == CMD_RUN) begin
                  if (s_q.scr_ok) begin
                     s_d.st = ST_RUN;
                     s_d.start = 1'b1;
                     s_d.ridx = 5'h1;
                  end else begin
                     s_d.ecode = ERR_EMPTY;
                  end
               end else begin
                  s_d.ecode = ERR_SYNTAX;
               end
            end else if (rx_take) begin
               if (!hx_ok) begin
                  s_d.bad = 1'b1;
               end else if (s_q.nargs < 4'(REG_ID_W)) begin
                  s_d.rid = {s_q.rid[3:0], hx_nib};
                  s_d.nargs = s_q.nargs + 4'h1;
               end else if (s_q.nval < ERR_LEN << 2) begin
                  s_d.val = {s_q.val[27:0], hx_nib};
                  s_d.nval = s_q.nval + 4'h1;
               end else begin
                  s_d.bad = 1'b1;
               end
            end
         end
         ST_LOAD: begin
            if (rx_take) begin
               s_d.we = (RX_DATA != CH_LF) && !s_q.bad;
               s_d.sd = RX_DATA;
               if (RX_DATA == CH_LF) begin
                  if (LINE_BAD && !s_q.ln_empty) begin
                     s_d.bad = 1'b1;
                     s_d.clr = 1'b1;
                     s_d.ecode = ERR_SYNTAX;
                  end
                  if (s_q.ln_empty) begin
                     s_d.scr_ok = !s_q.bad;
                     s_d.rlen = 4'h0;
                     if (s_q.run_ex && !s_q.bad) begin
                        s_d.st = ST_RUN;
                        s_d.start = 1'b1;
                        s_d.ridx = 5'h0;
                     end else begin
                        s_d.st = ST_RESP;
                     end
                  end
                  s_d.ln_empty = 1'b1;
               end else begin
                  s_d.ln_empty = 1'b0;
               end
            end
         end
         ST_RUN: begin
            if (rx_take && RX_DATA != CH_LF) begin
               s_d.hold_err = 1'b1;
            end
            // done pulse may land while a byte is still pending
            if (RUN_DONE) begin
               s_d.done = 1'b1;
            end
            if (!tx_busy) begin
               if (s_q.ridx == 5'h1) begin
                  tx_push = 1'b1;
                  tx_din = CH_LF;
                  s_d.ridx = 5'h0;
               end else if (RUN_OUT_VALID) begin
                  tx_push = 1'b1;
                  tx_din = RUN_OUT_DATA;
                  RUN_OUT_READY = 1'b1;
               end else if (RUN_DONE || s_q.done) begin
                  s_d.st = ST_RESP;
                  s_d.rlen = 4'h0;
                  s_d.ecode = s_d.hold_err ? ERR_BUSY : 8'h00;
                  s_d.hold_err = 1'b0;
                  s_d.done = 1'b0;
               end
            end
         end
         ST_RESP: begin
            if (!tx_busy) begin
               tx_push = 1'b1;
               if (s_q.rlen != 4'h0) begin
                  tx_din = hx_asc;
                  s_d.val = {s_q.val[27:0], 4'h0};
                  s_d.rlen = s_q.rlen - 4'h1;
               end else if (s_q.ecode != 8'h00) begin
                  tx_din = CH_ERR;
                  s_d.rlen = 4'h0;
                  s_d.cmd = s_q.ecode;
                  s_d.ecode = 8'h00;
                  s_d.nargs = 4'hf;
               end else if (s_q.nargs == 4'hf) begin
                  tx_din = s_q.cmd;
                  s_d.nargs = 4'h0;
               end else begin
                  tx_din = CH_LF;
                  s_d.st = ST_IDLE;
                  s_d.run_ex = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            if (!tx_busy) begin
               tx_push = 1'b1;
               tx_din = CH_LF;
               s_d.st = ST_HIB;
            end
         end
         ST_HIB: begin
            if (RX_VALID || wake_s) begin
               s_d.st = ST_GUARD;
               s_d.guard = 8'(HIB_GUARD_CYC);
            end
         end
         ST_GUARD: begin
            // bytes just after wake are dropped
            if (s_q.guard == 8'h00) begin
               s_d.st = ST_IDLE;
            end else begin
               s_d.guard = s_q.guard - 8'h01;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         s_q    <= '0;
         s_q.st <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign RUN_START  = s_q.start;
   assign SCR_DATA   = s_q.sd;
   assign SCR_WE     = s_q.we;
   assign SCR_CLEAR  = s_q.clr;
   assign NVM_STORE  = s_q.sto;
   assign NVM_RECALL = s_q.rec;
   assign HIBERNATE  = (s_q.st == ST_HIB);
endmodule
`default_nettype wire

// >>> test/aci_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module aci_top_asserts
   import aci_pkg::*;
(
   input wire logic       CLK_SYS,    // clock
   input wire logic       RST_B,      // reset, active low
   input wire logic       RX_VALID,   // byte in
   input wire logic       TX_VALID,   // byte out valid
   input wire logic [7:0] TX_DATA,    // byte out
   input wire logic       TX_READY,   // host takes byte
   input wire logic       WAKE,       // wake pin
   input wire logic       RUN_START,  // engine start
   input wire logic [7:0] SCR_DATA,   // ram byte
   input wire logic       SCR_WE,     // ram write
   input wire logic       SCR_CLEAR,  // ram wipe
   input wire logic       NVM_STORE,  // nvm store
   input wire logic       NVM_RECALL, // nvm recall
   input wire logic       HIBERNATE   // asleep
);
   // ========================================
   // properties
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   a_tx_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("tx byte changed before taken");
   a_no_cr_out: assert property (TX_VALID |-> TX_DATA != CH_CR)
      else $error("carriage return sent");
   a_ram_no_eol: assert property (SCR_WE |-> SCR_DATA != CH_LF && SCR_DATA != CH_CR)
      else $error("line end written to script ram");
   a_start_pulse: assert property (RUN_START |=> !RUN_START)
      else $error("run start longer than one cycle");
   a_clear_pulse: assert property (SCR_CLEAR |=> !SCR_CLEAR)
      else $error("ram wipe longer than one cycle");
   a_store_pulse: assert property (NVM_STORE |=> !NVM_STORE && !NVM_RECALL)
      else $error("store pulse malformed");
   a_recall_pulse: assert property (NVM_RECALL |=> !NVM_RECALL && !NVM_STORE)
      else $error("recall pulse malformed");
   // pin crosses two sync flops before the state leaves hibernate
   a_rx_wakes: assert property (HIBERNATE && RX_VALID |=> !HIBERNATE)
      else $error("no wake on received byte");
   a_pin_wakes: assert property (HIBERNATE && WAKE |-> ##[1:3] !HIBERNATE)
      else $error("no wake on wake pin");
endmodule
bind aci_top aci_top_asserts u_aci_top_asserts (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
   .RX_VALID(RX_VALID), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
   .WAKE(WAKE), .RUN_START(RUN_START), .SCR_DATA(SCR_DATA), .SCR_WE(SCR_WE),
   .SCR_CLEAR(SCR_CLEAR), .NVM_STORE(NVM_STORE), .NVM_RECALL(NVM_RECALL),
   .HIBERNATE(HIBERNATE));
`default_nettype wire

// >>> test/aci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module aci_host_model (
   input  wire logic       clk,      // system clock
   input  wire logic       tx_valid, // byte offered
   input  wire logic [7:0] tx_data,  // byte offered
   output logic            tx_ready  // take strobe
);
   byte unsigned rx_q[$];
   // random stalls make the sender hold its byte
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         rx_q.push_back(tx_data);
      tx_ready <= ($urandom % 4) != 0;
   end
endmodule
`default_nettype wire

// >>> test/ascii_command_interpreter_test.sv
`timescale 1ns/1ps
`default_nettype none
module ascii_command_interpreter_test
   import aci_pkg::*;
   ;
   // ========================================
   // signals and reference state
   logic       clk_sys = 1'b0, rst_b = 1'b0, rx_valid = 1'b0, wake = 1'b0;
   logic       out_valid = 1'b0, run_done = 1'b0, line_bad = 1'b0;
   logic [7:0] rx_data = 8'h00, out_data = 8'h00, nvm_ver = SCR_VER;
   logic       tx_valid, tx_ready, run_start, out_ready, scr_we, scr_clear;
   logic       nvm_store, nvm_recall, hibernate;
   logic [7:0] tx_data, scr_data;
   int         failures = 0, comparisons = 0, starts = 0, stores = 0, recalls = 0;
   int         regs[4] = '{0, 0, 0, 0};
   string      scr_s = "";
   always #50 clk_sys = ~clk_sys;
   aci_top u_aci_top (.CLK_SYS(clk_sys), .RST_B(rst_b), .RX_VALID(rx_valid), .RX_DATA(rx_data),
      .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .WAKE(wake),
      .RUN_START(run_start), .RUN_OUT_VALID(out_valid), .RUN_OUT_DATA(out_data),
      .RUN_OUT_READY(out_ready), .RUN_DONE(run_done), .LINE_BAD(line_bad),
      .SCR_DATA(scr_data), .SCR_WE(scr_we), .SCR_CLEAR(scr_clear), .NVM_STORE(nvm_store),
      .NVM_RECALL(nvm_recall), .NVM_VER(nvm_ver), .HIBERNATE(hibernate));
   aci_host_model u_host (.clk(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready));
   always @(posedge clk_sys) begin
      if (scr_clear === 1'b1)
         scr_s = "";
      if (scr_we === 1'b1)
         scr_s = {scr_s, string'(scr_data)};
      starts += int'(run_start === 1'b1);
      stores += int'(nvm_store === 1'b1);
      recalls += int'(nvm_recall === 1'b1);
   end
   // ========================================
   // helpers
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic fail_wait();
      failures++;
      $display("MISMATCH wait expected done seen timeout");
      give_verdict();
   endtask
   task automatic check_str(string what, string exp, string got);
      comparisons++;
      if (exp != got) begin
         failures++;
         $display("MISMATCH %s expected %s seen %s", what, exp, got);
      end
   endtask
   task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   function automatic string hexs(int unsigned v, int w);
      string d = "0123456789ABCDEF";
      hexs = "";
      for (int i = w - 1; i >= 0; i--)
         hexs = {hexs, string'(d[(v >> (4 * i)) & 15])};
   endfunction
   function automatic logic pick(int w);
      case (w)
         0: return tx_valid;
         1: return out_ready;
         2: return hibernate;
         default: return logic'(starts >= w - 2);
      endcase
   endfunction
   task automatic await(int w, logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
         if (n > 3000)
            fail_wait();
      end while (pick(w) !== lvl);
   endtask
   // bytes are held back while an answer byte is pending
   task automatic send_line(string s);
      string t;
      t = {s, "\n"};
      foreach (t[i]) begin
         await(0, 1'b0);
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_data <= t[i];
         @(posedge clk_sys);
         rx_valid <= 1'b0;
      end
   endtask
   task automatic expect_line(string what, string exp);
      string got;
      int n;
      got = "";
      n = 0;
      while (!(8'h0a inside {u_host.rx_q})) begin
         @(negedge clk_sys);
         n++;
         if (n > 3000)
            fail_wait();
      end
      while (u_host.rx_q[0] != 8'h0a)
         got = {got, string'(u_host.rx_q.pop_front())};
      void'(u_host.rx_q.pop_front());
      check_str(what, exp, got);
   endtask
   task automatic script_out(string s, bit fin);
      @(posedge clk_sys);
      foreach (s[i]) begin
         out_valid <= 1'b1;
         out_data <= s[i];
         await(1, 1'b1);
         @(posedge clk_sys);
      end
      out_valid <= 1'b0;
      run_done <= fin;
      @(posedge clk_sys);
      run_done <= 1'b0;
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys);
      fail_wait();
   end
   // ========================================
   // scenarios
   initial begin
      int unsigned v;
      int          w;
      string       cmd[3] = '{"G07", "S001", "G0Z"};
      void'($urandom(32'hcbb4500c));
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         send_line({"S02", hexs(p, 2)});
         expect_line("set perm", "S");
         regs[2] = p;
         for (int id = 0; id < 4; id++) begin
            w = (id == 1) ? 4 : (id == 2) ? 2 : 8;
            v = (w == 4) ? ($urandom & 32'hffff) : $urandom;
            if (id != 2) begin
               send_line({"S", hexs(id, 2), hexs(v, w)});
               if (id % 2 == 1 && p == 0)
                  expect_line("set refused", "S!3");
               else begin
                  expect_line("set", "S");
                  regs[id] = v;
               end
            end
            send_line({"G", hexs(id, 2)});
            expect_line("get", (id % 2 == 1 && p == 0) ? "G!3" : {"G", hexs(regs[id], w)});
         end
      end
      foreach (cmd[i]) begin
         send_line(cmd[i]);
         expect_line("bad arg", {cmd[i].substr(0, 0), "!2"});
      end
      send_line("G\r00");
      expect_line("cr dropped", {"G", hexs(regs[0], 8)});
      $display("test registers done");
      send_line("l\nabc\n");
      expect_line("load", "l");
      check_str("ram", "abc", scr_s);
      send_line("r");
      expect_line("run", "r");
      await(3, 1'b1);
      script_out("hi\n", 1'b0);
      expect_line("script out", "hi");
      send_line("G00");
      script_out("", 1'b1);
      expect_line("busy close", "!4");
      send_line("Fmscr");
      expect_line("store", "F");
      check_val("store pulses", 1, stores);
      $display("test load run store done");
      @(posedge clk_sys);
      line_bad <= 1'b1;
      send_line("l\nbad");
      @(posedge clk_sys);
      line_bad <= 1'b0;
      send_line("");
      expect_line("bad load", "l!1");
      repeat (50) @(posedge clk_sys);
      u_host.rx_q.delete();
      check_str("ram wiped", "", scr_s);
      send_line("r");
      expect_line("run empty", "r!6");
      send_line("Fmscr");
      expect_line("store empty", "F!6");
      send_line("x");
      expect_line("unknown", "x!1");
      @(posedge clk_sys);
      nvm_ver <= SCR_VER + 8'h01;
      send_line("Lmscr");
      expect_line("recall old", "L!5");
      @(posedge clk_sys);
      nvm_ver <= SCR_VER;
      send_line("Lmscr");
      expect_line("recall", "L");
      check_val("recall pulses", 1, recalls);
      send_line("r");
      expect_line("run recalled", "r");
      await(4, 1'b1);
      script_out("", 1'b1);
      expect_line("run close", "");
      $display("test parse error and recall done");
      send_line("e\nab\n");
      await(5, 1'b1);
      script_out("x\n", 1'b1);
      expect_line("exec", "ex");
      expect_line("exec close", "");
      check_str("exec ram", "ab", scr_s);
      $display("test execute done");
      for (int k = 0; k < 2; k++) begin
         send_line("s");
         expect_line("hibernate", "s");
         await(2, 1'b1);
         @(posedge clk_sys);
         rx_valid <= (k == 0);
         wake <= (k == 1);
         @(posedge clk_sys);
         rx_valid <= 1'b0;
         await(2, 1'b0);
         @(posedge clk_sys);
         wake <= 1'b0;
         repeat (30) @(posedge clk_sys);
         u_host.rx_q.delete();
      end
      send_line("G02");
      expect_line("awake", "G01");
      $display("test hibernate done");
      give_verdict();
   end
endmodule
`default_nettype wire
